// [hdl/tcop_cfg.svh]
`ifndef TCOP_CFG_SVH
`define TCOP_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TCOP_ADR_CTL1 8'h00
`define TCOP_ADR_CTL2 8'h04
`define TCOP_ADR_STATUS 8'h08
`define TCOP_ADR_CMP1HI 8'h0c
`define TCOP_ADR_CMP1LO 8'h10
`define TCOP_ADR_CMP2HI 8'h14
`define TCOP_ADR_CMP2LO 8'h18
`define TCOP_ADR_CAP1HI 8'h1c
`define TCOP_ADR_CAP1LO 8'h20
`define TCOP_ADR_CAP2HI 8'h24
`define TCOP_ADR_CAP2LO 8'h28
`define TCOP_ADR_CNTHI 8'h2c
`define TCOP_ADR_CNTLO 8'h30
// ----------------------------------------
// control_one bits
// ----------------------------------------
`define TCOP_C1_LVL 0
`define TCOP_C1_EDGE1 2
`define TCOP_C1_FORCE 3
`define TCOP_C1_CAPTURE_IRQ_ENABLE 5
`define TCOP_C1_COMPARE_IRQ_ENABLE 6
`define TCOP_C1_KEEP 8'he7
// ----------------------------------------
// control_two bits
// ----------------------------------------
`define TCOP_C2_DRIVE 0
`define TCOP_C2_PWM 2
`define TCOP_C2_OPM 3
`define TCOP_C2_DIVLO 4
`define TCOP_C2_DIVHI 5
`define TCOP_C2_EDGE2 6
`define TCOP_C2_EXTEDGE 7
// ----------------------------------------
// reset and reload values
// ----------------------------------------
`define TCOP_CMP_RESET 16'h8000
`define TCOP_CNT_RELOAD 16'hfffc
`define TCOP_CAP_OPM 16'hfffd
`define TCOP_PRE_DIV2 3'h1
`define TCOP_PRE_DIV4 3'h3
`define TCOP_PRE_DIV8 3'h7
`endif

// [hdl/tcop_core.sv]
// How it works
// - match sets flag, drives pin, requests irq
// - two 16-bit compares checked every tick
// - compare values software only, reset 8000h
// - match drives level bit; pin low in reset
// - compare irq needs enable and mask clear
// - flag clears after status read, low access
// - high write blocks matches until low write
// - drive off: pin untouched, irq still possible
// - div2 matches at value, others value+1
// - force copies level, no flag, no irq
// - force ignored in single-pulse or pwm
// - single-pulse uses capture 1 and compare 1
// - trigger reloads counter, pulse level, capture fffd
// - compare 1 match gives after-pulse level
// - single-pulse: flag 1 never, flag 2 works
// - pwm select overrides single-pulse select
// - single-pulse: capture 1 off, capture 2 works
// - single-pulse: compare 2 flags, no waveform
// - trigger flag requests irq if capture enabled
// - capture flag clears after status, low access
// - equal levels keep pulse pin constant
// - tick is clock over 2, 4 or 8
// - both divide bits select external clock
// - counter resets and reloads only fffch
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`include "tcop_cfg.svh"
module tcop_core
  import tcop_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cpuIrqMask,
  input wire logic capturePin1,
  input wire logic capturePin2,
  input wire logic extClockPin,
  output logic [1:0] compareOutPin,
  output logic [1:0] compareOutEn,
  output logic timerIrq
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rstPipe_reg;
  logic rstSync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe_reg <= 2'b00;
    else
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end
  assign rstSync_n = rstPipe_reg[1];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pinIn;
  logic [2:0] syncA_reg, syncB_reg, syncC_reg, level_reg;
  logic [2:0] pinRise, pinFall;

  assign pinIn = {extClockPin, capturePin2, capturePin1};
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gSync
      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
        begin
          syncA_reg[g] <= 1'b0;
          syncB_reg[g] <= 1'b0;
          syncC_reg[g] <= 1'b0;
          level_reg[g] <= 1'b0;
        end
        else
        begin
          syncA_reg[g] <= pinIn[g];
          syncB_reg[g] <= syncA_reg[g];
          syncC_reg[g] <= syncB_reg[g];
          // a change counts only when two stages agree
          if (syncB_reg[g] == syncC_reg[g])
            level_reg[g] <= syncC_reg[g];
        end
      end
      assign pinRise[g] = (syncB_reg[g] == syncC_reg[g]) &&
                          syncC_reg[g] && !level_reg[g];
      assign pinFall[g] = (syncB_reg[g] == syncC_reg[g]) &&
                          !syncC_reg[g] && level_reg[g];
    end
  endgenerate

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic busReq, wrEn, rdEn, rdStatus, wrCtl1, wrCtl2, wrCntLo;
  logic [7:0] wbData;
  logic ack_reg;

  assign busReq = cyc_i && stb_i && !ack_reg;
  assign wrEn = busReq && we_i && sel_i[0];
  assign rdEn = busReq && !we_i;
  assign wbData = dat_i[7:0];
  assign rdStatus = rdEn && (adr_i == `TCOP_ADR_STATUS);
  assign wrCtl1 = wrEn && (adr_i == `TCOP_ADR_CTL1);
  assign wrCtl2 = wrEn && (adr_i == `TCOP_ADR_CTL2);
  assign wrCntLo = wrEn && (adr_i == `TCOP_ADR_CNTLO);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0] ctl1_reg, ctl2_reg;
  logic opmActive, pwmActive;
  tcop_clkdiv_t clkDiv;

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      ctl1_reg <= 8'h00;
    else if (wrCtl1)
      ctl1_reg <= wbData & `TCOP_C1_KEEP;
  end

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      ctl2_reg <= 8'h00;
    else if (wrCtl2)
      ctl2_reg <= wbData;
  end

  assign pwmActive = ctl2_reg[`TCOP_C2_PWM];
  assign opmActive = ctl2_reg[`TCOP_C2_OPM] && !pwmActive;
  assign clkDiv = tcop_clkdiv_t'(ctl2_reg[`TCOP_C2_DIVHI:`TCOP_C2_DIVLO]);

  // ----------------------------------------
  // prescaler and counter
  // ----------------------------------------
  logic [2:0] pre_reg, preEnd;
  logic tick, extEdge, tickFresh_reg, opmTrig;
  logic [15:0] count_reg;
  logic [1:0] capEdge;

  always_comb
  begin
    unique case (clkDiv)
      TCOP_DIV2: preEnd = `TCOP_PRE_DIV2;
      TCOP_DIV4: preEnd = `TCOP_PRE_DIV4;
      TCOP_DIV8: preEnd = `TCOP_PRE_DIV8;
      TCOP_EXT: preEnd = `TCOP_PRE_DIV8;
    endcase
  end

  assign extEdge = ctl2_reg[`TCOP_C2_EXTEDGE] ? pinRise[2] : pinFall[2];
  assign tick = (clkDiv == TCOP_EXT) ? extEdge
                                     : (pre_reg == preEnd);

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      pre_reg <= 3'h0;
    else if (pre_reg == preEnd)
      pre_reg <= 3'h0;
    else
      pre_reg <= pre_reg + 3'h1;
  end

  assign capEdge[0] = ctl1_reg[`TCOP_C1_EDGE1] ? pinRise[0] : pinFall[0];
  assign capEdge[1] = ctl2_reg[`TCOP_C2_EDGE2] ? pinRise[1] : pinFall[1];
  assign opmTrig = opmActive && capEdge[0];

  // counter shares this clock with the compare logic
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      count_reg <= `TCOP_CNT_RELOAD;
    else if (opmTrig || wrCntLo)
      count_reg <= `TCOP_CNT_RELOAD;
    else if (tick)
      count_reg <= count_reg + 16'h0001;
  end

  // compare looks at the value one cycle after it moved
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      tickFresh_reg <= 1'b0;
    else
      tickFresh_reg <= tick || opmTrig;
  end

  // ----------------------------------------
  // compare and capture channels
  // ----------------------------------------
  logic [15:0] cmpVal_reg [0:1];
  logic [15:0] capVal_reg [0:1];
  logic [1:0] inhibit_reg, ocf_reg, ocfArm_reg, pin_reg;
  logic [1:0] capInh_reg, icf_reg, icfArm_reg;
  logic [1:0] matchEvt, ocfSet, forceHit;
  logic [1:0] wrCmpHi, wrCmpLo, accCmpLo, rdCapHi, accCapLo;
  logic [1:0] capNormal;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : gChan
      localparam logic [7:0] AHI = i ? `TCOP_ADR_CMP2HI : `TCOP_ADR_CMP1HI;
      localparam logic [7:0] ALO = i ? `TCOP_ADR_CMP2LO : `TCOP_ADR_CMP1LO;
      localparam logic [7:0] CHI = i ? `TCOP_ADR_CAP2HI : `TCOP_ADR_CAP1HI;
      localparam logic [7:0] CLO = i ? `TCOP_ADR_CAP2LO : `TCOP_ADR_CAP1LO;
      logic [15:0] target;

      assign wrCmpHi[i] = wrEn && (adr_i == AHI);
      assign wrCmpLo[i] = wrEn && (adr_i == ALO);
      assign accCmpLo[i] = busReq && (adr_i == ALO);
      assign rdCapHi[i] = rdEn && (adr_i == CHI);
      assign accCapLo[i] = busReq && (adr_i == CLO);

      // slower ticks see the match one count late
      assign target = (clkDiv == TCOP_DIV2) ? cmpVal_reg[i]
                    : cmpVal_reg[i] + 16'h0001;
      assign matchEvt[i] = tickFresh_reg && !inhibit_reg[i] &&
                           !pwmActive && (count_reg == target);
      assign ocfSet[i] = matchEvt[i] && !(i == 0 && opmActive);
      assign forceHit[i] = wrCtl1 && wbData[`TCOP_C1_FORCE + i] &&
                           !ctl2_reg[`TCOP_C2_OPM] && !pwmActive;
      assign capNormal[i] = capEdge[i] && !capInh_reg[i] &&
                            !(i == 0 && (opmActive || pwmActive));

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          cmpVal_reg[i] <= `TCOP_CMP_RESET;
        else if (wrCmpHi[i])
          cmpVal_reg[i][15:8] <= wbData;
        else if (wrCmpLo[i])
          cmpVal_reg[i][7:0] <= wbData;
      end

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          inhibit_reg[i] <= 1'b0;
        else if (wrCmpHi[i])
          inhibit_reg[i] <= 1'b1;
        else if (wrCmpLo[i])
          inhibit_reg[i] <= 1'b0;
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          ocf_reg[i] <= 1'b0;
        else if (ocfSet[i])
          ocf_reg[i] <= 1'b1;
        else if (accCmpLo[i] && ocfArm_reg[i])
          ocf_reg[i] <= 1'b0;
      end

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          ocfArm_reg[i] <= 1'b0;
        else if (accCmpLo[i])
          ocfArm_reg[i] <= 1'b0;
        else if (rdStatus && ocf_reg[i])
          ocfArm_reg[i] <= 1'b1;
      end

      // without drive the pin is gpio and the latch is left alone
      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          pin_reg[i] <= 1'b0;
        else if (!ctl2_reg[`TCOP_C2_DRIVE + i])
          pin_reg[i] <= pin_reg[i];
        else if (i == 0 && opmTrig)
          pin_reg[i] <= ctl1_reg[`TCOP_C1_LVL + 1];
        else if (matchEvt[i] && !(i == 1 && opmActive))
          pin_reg[i] <= ctl1_reg[`TCOP_C1_LVL + i];
        else if (forceHit[i])
          pin_reg[i] <= wbData[`TCOP_C1_LVL + i];
      end

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          capVal_reg[i] <= 16'h0000;
        else if (i == 0 && opmTrig)
          capVal_reg[i] <= `TCOP_CAP_OPM;
        else if (capNormal[i])
          capVal_reg[i] <= count_reg;
      end

      // reading the high byte freezes capture until low is accessed
      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          capInh_reg[i] <= 1'b0;
        else if (rdCapHi[i])
          capInh_reg[i] <= 1'b1;
        else if (accCapLo[i])
          capInh_reg[i] <= 1'b0;
      end

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          icf_reg[i] <= 1'b0;
        else if (capNormal[i] || (i == 0 && opmTrig))
          icf_reg[i] <= 1'b1;
        else if (accCapLo[i] && icfArm_reg[i])
          icf_reg[i] <= 1'b0;
      end

      always_ff @(posedge clock or negedge rstSync_n)
      begin
        if (!rstSync_n)
          icfArm_reg[i] <= 1'b0;
        else if (accCapLo[i])
          icfArm_reg[i] <= 1'b0;
        else if (rdStatus && icf_reg[i])
          icfArm_reg[i] <= 1'b1;
      end
    end
  endgenerate

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  logic irq_reg;

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= !cpuIrqMask &&
                 ((ctl1_reg[`TCOP_C1_COMPARE_IRQ_ENABLE] && |ocf_reg) ||
                  (ctl1_reg[`TCOP_C1_CAPTURE_IRQ_ENABLE] && |icf_reg));
  end

  // ----------------------------------------
  // read mux and acknowledge
  // ----------------------------------------
  logic [7:0] rdMux;
  logic [31:0] dat_reg;

  always_comb
  begin
    unique case (adr_i)
      `TCOP_ADR_CTL1: rdMux = ctl1_reg;
      `TCOP_ADR_CTL2: rdMux = ctl2_reg;
      `TCOP_ADR_STATUS: rdMux = {4'h0, icf_reg, ocf_reg};
      `TCOP_ADR_CMP1HI: rdMux = cmpVal_reg[0][15:8];
      `TCOP_ADR_CMP1LO: rdMux = cmpVal_reg[0][7:0];
      `TCOP_ADR_CMP2HI: rdMux = cmpVal_reg[1][15:8];
      `TCOP_ADR_CMP2LO: rdMux = cmpVal_reg[1][7:0];
      `TCOP_ADR_CAP1HI: rdMux = capVal_reg[0][15:8];
      `TCOP_ADR_CAP1LO: rdMux = capVal_reg[0][7:0];
      `TCOP_ADR_CAP2HI: rdMux = capVal_reg[1][15:8];
      `TCOP_ADR_CAP2LO: rdMux = capVal_reg[1][7:0];
      `TCOP_ADR_CNTHI: rdMux = count_reg[15:8];
      `TCOP_ADR_CNTLO: rdMux = count_reg[7:0];
      default: rdMux = 8'h00;
    endcase
  end

  // unmapped addresses still ack, reading zero
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= busReq;
      dat_reg <= rdEn ? {24'h00_0000, rdMux} : 32'h0000_0000;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign timerIrq = irq_reg;
  assign compareOutPin = pin_reg;
  assign compareOutEn = ctl2_reg[`TCOP_C2_DRIVE + 1:`TCOP_C2_DRIVE];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSync_n);

  property p_flag2Sets;
    matchEvt[1] |=> ocf_reg[1];
  endproperty
  a_flag2Sets: assert property (p_flag2Sets)
    else $error("compare flag 2 missed a match");

  property p_pinLevel;
    matchEvt[0] && ctl2_reg[`TCOP_C2_DRIVE] && !opmTrig
      |=> pin_reg[0] == $past(ctl1_reg[`TCOP_C1_LVL]);
  endproperty
  a_pinLevel: assert property (p_pinLevel)
    else $error("compare pin 1 did not take its level");

  property p_irqMask;
    $rose(timerIrq) |-> !$past(cpuIrqMask) &&
      ($past(ctl1_reg[`TCOP_C1_COMPARE_IRQ_ENABLE]) || $past(ctl1_reg[`TCOP_C1_CAPTURE_IRQ_ENABLE]));
  endproperty
  a_irqMask: assert property (p_irqMask)
    else $error("interrupt raised while masked or disabled");

  property p_cmpStable;
    !wrCmpHi[0] && !wrCmpLo[0] |=> $stable(cmpVal_reg[0]);
  endproperty
  a_cmpStable: assert property (p_cmpStable)
    else $error("compare value 1 changed without a write");

  property p_inhibit;
    inhibit_reg[1] && !ocf_reg[1] |=> !ocf_reg[1];
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("match flagged while inhibited");

  property p_gpioPin;
    !ctl2_reg[`TCOP_C2_DRIVE + 1] |=> $stable(pin_reg[1]);
  endproperty
  a_gpioPin: assert property (p_gpioPin)
    else $error("pin 2 moved with drive disabled");

  property p_opmTrigger;
    opmTrig |=> count_reg == `TCOP_CNT_RELOAD &&
      capVal_reg[0] == `TCOP_CAP_OPM && icf_reg[0];
  endproperty
  a_opmTrigger: assert property (p_opmTrigger)
    else $error("trigger did not reload counter and capture");

  property p_noFlag1Opm;
    opmActive && !ocf_reg[0] |=> !ocf_reg[0];
  endproperty
  a_noFlag1Opm: assert property (p_noFlag1Opm)
    else $error("flag 1 set in single-pulse mode");

  property p_forceNoFlag;
    forceHit != 2'b00 && matchEvt == 2'b00 |=> $stable(ocf_reg);
  endproperty
  a_forceNoFlag: assert property (p_forceNoFlag)
    else $error("force changed a compare flag");

  // looks back so a later divider change cannot trip it
  property p_div4Spacing;
    tick && clkDiv == TCOP_DIV4 && $past(clkDiv) == TCOP_DIV4 &&
      $past(clkDiv, 2) == TCOP_DIV4 && $past(clkDiv, 3) == TCOP_DIV4
      |-> !$past(tick) && !$past(tick, 2) && !$past(tick, 3);
  endproperty
  a_div4Spacing: assert property (p_div4Spacing)
    else $error("divide-by-4 tick came early");

endmodule // tcop_core

// [hdl/tcop_pkg.sv]
package tcop_pkg;
  typedef enum logic [1:0] {
    TCOP_DIV2 = 2'b00,
    TCOP_DIV4 = 2'b01,
    TCOP_DIV8 = 2'b10,
    TCOP_EXT = 2'b11
  } tcop_clkdiv_t;
endpackage

// [sim/tcop_core_tb.sv]
`include "tcop_cfg.svh"
module tcop_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock;
  logic rst_n;
  logic cyc, stb, we, ack, irqMask, timerIrq;
  logic capturePin1, capturePin2, extClockPin;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wrData, rdData;
  logic [1:0] compareOutPin, compareOutEn;
  logic [7:0] q;
  int n_mismatch = 0;
  int comparisons = 0;

  tcop_core u_tcop_core (
    .clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wrData), .dat_o(rdData),
    .ack_o(ack), .cpuIrqMask(irqMask), .capturePin1(capturePin1),
    .capturePin2(capturePin2), .extClockPin(extClockPin),
    .compareOutPin(compareOutPin), .compareOutEn(compareOutEn),
    .timerIrq(timerIrq)
  );

  tcop_cpu_model u_tcop_cpu_model (
    .clock(clock), .ack(ack), .rdData(rdData), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wrData(wrData), .irqMask(irqMask)
  );

  // ----------
  // helpers
  // ----------
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus_ok();
    if (u_tcop_cpu_model.busOk !== 1'b1)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_tcop_cpu_model.access(1'b1, a, d, x);
    bus_ok();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    u_tcop_cpu_model.access(1'b0, a, 8'h00, d);
    bus_ok();
  endtask

  // bounded wait for pin 1; running out shows as a mismatch
  task automatic wait_pin(input logic v, input int lim);
    int n;
    n = 0;
    while (compareOutPin[0] !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk("pin1 wait", {7'h0, v}, {7'h0, compareOutPin[0]});
    if (compareOutPin[0] !== v)
      end_of_test();
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset();
    chk("pins", 8'h00, {4'h0, compareOutEn, compareOutPin});
    rd(`TCOP_ADR_CMP1HI, q);
    chk("cmp1 hi", 8'h80, q);
    rd(`TCOP_ADR_CMP1LO, q);
    chk("cmp1 lo", 8'h00, q);
    rd(`TCOP_ADR_CMP2HI, q);
    chk("cmp2 hi", 8'h80, q);
    rd(`TCOP_ADR_CMP2LO, q);
    chk("cmp2 lo", 8'h00, q);
    rd(8'h3c, q);
    chk("unmapped", 8'h00, q);
    wr(`TCOP_ADR_CMP1LO, 8'h5a);
    rd(`TCOP_ADR_CMP1LO, q);
    chk("cmp1 lo rw", 8'h5a, q);
  endtask

  task automatic t_match();
    wr(`TCOP_ADR_CTL1, 8'h41);
    wr(`TCOP_ADR_CTL2, 8'h01);
    wr(`TCOP_ADR_CNTLO, 8'h00);
    u_tcop_cpu_model.set_cmp(`TCOP_ADR_CMP1HI, `TCOP_ADR_CMP1LO, 16'h0010);
    wait_pin(1'b1, 200);
    chk("drive en", 8'h01, {6'h0, compareOutEn});
    rd(`TCOP_ADR_CMP1LO, q);
    chk("irq", 8'h01, {7'h0, timerIrq});
    u_tcop_cpu_model.irqMask <= 1'b1;
    repeat (3) @(posedge clock);
    chk("irq masked", 8'h00, {7'h0, timerIrq});
    u_tcop_cpu_model.irqMask <= 1'b0;
    rd(`TCOP_ADR_STATUS, q);
    chk("ocf1 set", 8'h01, q & 8'h01);
    rd(`TCOP_ADR_CMP1LO, q);
    rd(`TCOP_ADR_STATUS, q);
    chk("ocf1 clear", 8'h00, q & 8'h01);
    chk("irq clear", 8'h00, {7'h0, timerIrq});
  endtask

  task automatic t_inhibit();
    wr(`TCOP_ADR_CNTLO, 8'h00);
    wr(`TCOP_ADR_CMP2HI, 8'h00);
    repeat (40) @(posedge clock);
    rd(`TCOP_ADR_STATUS, q);
    chk("ocf2 held", 8'h00, q & 8'h02);
    wr(`TCOP_ADR_CNTLO, 8'h00);
    wr(`TCOP_ADR_CMP2LO, 8'h08);
    repeat (60) @(posedge clock);
    rd(`TCOP_ADR_STATUS, q);
    chk("ocf2 set", 8'h02, q & 8'h02);
  endtask

  task automatic t_force();
    // matches during the inhibit test left flag 1 set
    rd(`TCOP_ADR_STATUS, q);
    rd(`TCOP_ADR_CMP1LO, q);
    wr(`TCOP_ADR_CTL1, 8'h08);
    repeat (2) @(posedge clock);
    chk("force low", 8'h00, {7'h0, compareOutPin[0]});
    rd(`TCOP_ADR_STATUS, q);
    chk("force no flag", 8'h00, q & 8'h01);
    wr(`TCOP_ADR_CTL1, 8'h09);
    repeat (2) @(posedge clock);
    chk("force high", 8'h01, {7'h0, compareOutPin[0]});
    wr(`TCOP_ADR_CTL2, 8'h00);
    repeat (2) @(posedge clock);
    chk("drive off", 8'h00, {6'h0, compareOutEn});
  endtask

  task automatic t_pulse();
    wr(`TCOP_ADR_CTL2, 8'h09);
    wr(`TCOP_ADR_CTL1, 8'h08);
    repeat (2) @(posedge clock);
    chk("force ignored", 8'h01, {7'h0, compareOutPin[0]});
    wr(`TCOP_ADR_CTL1, 8'h25);
    u_tcop_cpu_model.set_cmp(`TCOP_ADR_CMP1HI, `TCOP_ADR_CMP1LO, 16'h0040);
    capturePin1 <= 1'b1;
    wait_pin(1'b0, 20);
    repeat (2) @(posedge clock);
    chk("trigger irq", 8'h01, {7'h0, timerIrq});
    rd(`TCOP_ADR_STATUS, q);
    chk("capture_flag_1 set", 8'h04, q & 8'h05);
    rd(`TCOP_ADR_CAP1HI, q);
    chk("cap1 hi", 8'hff, q);
    rd(`TCOP_ADR_CAP1LO, q);
    chk("cap1 lo", 8'hfd, q);
    rd(`TCOP_ADR_STATUS, q);
    chk("capture_flag_1 clear", 8'h00, q & 8'h04);
    wait_pin(1'b1, 400);
    rd(`TCOP_ADR_STATUS, q);
    chk("ocf1 never", 8'h00, q & 8'h01);
    wr(`TCOP_ADR_CTL2, 8'h0d);
    capturePin1 <= 1'b0;
    repeat (8) @(posedge clock);
    capturePin1 <= 1'b1;
    repeat (10) @(posedge clock);
    chk("pwm wins", 8'h01, {7'h0, compareOutPin[0]});
  endtask

  // counter read lands four cycles after the matching tick
  task automatic t_div();
    wr(`TCOP_ADR_CTL1, 8'h00);
    wr(`TCOP_ADR_CTL2, 8'h21);
    u_tcop_cpu_model.set_cmp(`TCOP_ADR_CMP1HI, `TCOP_ADR_CMP1LO, 16'h0004);
    wr(`TCOP_ADR_CNTLO, 8'h00);
    wait_pin(1'b0, 200);
    rd(`TCOP_ADR_CNTLO, q);
    chk("div8 match", 8'h05, q);
    wr(`TCOP_ADR_CTL2, 8'h11);
    wr(`TCOP_ADR_CNTLO, 8'h00);
    // sixteen cycles between reload and sampled read
    repeat (14) @(posedge clock);
    rd(`TCOP_ADR_CNTLO, q);
    chk("div4 ticks", 8'h00, q);
    wr(`TCOP_ADR_CTL2, 8'hb1);
    wr(`TCOP_ADR_CNTLO, 8'h00);
    repeat (3)
    begin
      extClockPin <= 1'b1;
      repeat (8) @(posedge clock);
      extClockPin <= 1'b0;
      repeat (8) @(posedge clock);
    end
    rd(`TCOP_ADR_CNTLO, q);
    chk("ext ticks", 8'hff, q);
  endtask

  task automatic t_levels();
    logic [1:0] seen;
    seen = 2'b01;
    rd(`TCOP_ADR_STATUS, q);
    rd(`TCOP_ADR_CMP1LO, q);
    rd(`TCOP_ADR_CMP2LO, q);
    wr(`TCOP_ADR_CTL1, 8'h27);
    wr(`TCOP_ADR_CTL2, 8'h6b);
    capturePin1 <= 1'b0;
    repeat (8) @(posedge clock);
    capturePin1 <= 1'b1;
    capturePin2 <= 1'b1;
    wait_pin(1'b1, 20);
    repeat (130)
    begin
      @(posedge clock);
      seen = {seen[1] | compareOutPin[1], seen[0] & compareOutPin[0]};
    end
    chk("drive both", 8'h03, {6'h0, compareOutEn});
    chk("opm levels", 8'h01, {6'h0, seen});
    rd(`TCOP_ADR_STATUS, q);
    chk("opm flags", 8'h0e, q);
  endtask

  // ----------
  // clock, reset, sequence
  // ----------
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    rst_n = 1'b0;
    capturePin1 = 1'b0;
    capturePin2 = 1'b0;
    extClockPin = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_match();
    t_inhibit();
    t_force();
    t_pulse();
    t_div();
    t_levels();
    end_of_test();
  end
endmodule // tcop_core_tb

// [sim/tcop_cpu_model.sv]
// ----------
// cpu side: bus master and interrupt mask
// ----------
`include "tcop_cfg.svh"
module tcop_cpu_model (
  input wire logic clock,
  input wire logic ack,
  input wire logic [31:0] rdData,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wrData,
  output logic irqMask
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busOk;

  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wrData = 32'h0;
    irqMask = 1'b0;
    busOk = 1'b1;
  end

  task automatic access(
    input logic w,
    input logic [7:0] a,
    input logic [7:0] d,
    output logic [7:0] q
  );
    int n;
    n = 0;
    q = 8'h00;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wrData <= {24'h0, d};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      busOk = 1'b0;
    q = rdData[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // released lines must not look like the last value
    adr <= ~a;
    wrData <= ~{24'h0, d};
  endtask

  // high, status, low keeps a stale flag from slipping in
  task automatic set_cmp(
    input logic [7:0] hiAdr,
    input logic [7:0] loAdr,
    input logic [15:0] v
  );
    logic [7:0] x;
    access(1'b1, hiAdr, v[15:8], x);
    access(1'b0, `TCOP_ADR_STATUS, 8'h00, x);
    access(1'b1, loAdr, v[7:0], x);
  endtask
endmodule // tcop_cpu_model
